/* File: rtl/pcd_pkg.sv */
// Constants for the port pin configuration and change-detect block.
// Assumes a 4-bit word address on the register port and 8-bit data.
`default_nettype none
package pcd_pkg;
    // Register port, pin and synchroniser widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PINS_W = 16;   // Both ports, first port in the low byte
    localparam int unsigned SYNC_W = 17;   // Pins plus the master-clear selection

    // Register offsets
    localparam logic [3:0] OFS_PORT_A_DATA      = 4'h0;
    localparam logic [3:0] OFS_PORT_B_DATA      = 4'h1;
    localparam logic [3:0] OFS_PORT_A_DIRECTION = 4'h2;
    localparam logic [3:0] OFS_PORT_B_DIRECTION = 4'h3;
    localparam logic [3:0] OFS_PORT_B_PULLUP    = 4'h4;
    localparam logic [3:0] OFS_PORT_B_ANALOG    = 4'h5;
    localparam logic [3:0] OFS_CHANGE_EN_A      = 4'h6;
    localparam logic [3:0] OFS_CHANGE_EN_B      = 4'h7;
    localparam logic [3:0] OFS_INT_STATUS       = 4'h8;
    localparam logic [3:0] OFS_INT_MASK         = 4'h9;
    localparam logic [3:0] OFS_PULLUP_CTRL      = 4'ha;

    // Implemented bits of each register
    localparam logic [7:0] MASK_PORT_A     = 8'hff;
    localparam logic [7:0] MASK_PORT_B     = 8'hf3;
    localparam logic [7:0] MASK_PULLUP_B   = 8'hf2;
    localparam logic [7:0] MASK_ANALOG_B   = 8'h72;
    localparam logic [7:0] MASK_CHANGE_A   = 8'hef;
    localparam logic [7:0] MASK_CHANGE_B   = 8'hf3;

    // Values after reset
    localparam logic [7:0] RST_DIRECTION   = 8'hff;
    localparam logic [7:0] RST_OUT_DATA    = 8'h00;
    localparam logic [7:0] RST_PULLUP_B    = 8'hf2;
    localparam logic [7:0] RST_ANALOG_B    = 8'h72;
    localparam logic [7:0] RST_CHANGE      = 8'h00;
    localparam logic       RST_FLAG        = 1'b0;
    localparam logic       RST_INT_EN      = 1'b0;
    localparam logic       RST_PULLUP_GLB  = 1'b0;
    localparam logic [15:0] RST_CMP_LATCH  = 16'h0000;

    // Field positions
    localparam int unsigned BIT_CHANGE_FLAG   = 0;
    localparam int unsigned BIT_CHANGE_IE     = 0;
    localparam int unsigned BIT_PULLUP_GLB    = 0;
    localparam int unsigned BIT_MASTER_CLEAR_PIN_PIN      = 5;
    localparam int unsigned BIT_OPEN_DRAIN    = 0;

    // Synchroniser depth in cycles
    localparam int unsigned SYNC_STAGES = 2;
endpackage : pcd_pkg
`default_nettype wire

/* File: rtl/pcd_det_if.sv */
// Carrier between the top and the change detector.
// Assumes both ends run on the same clock.
`default_nettype none
interface pcd_det_if;
    import pcd_pkg::*;
    logic [PINS_W-1:0] level;     // Synchronised pin levels
    logic [PINS_W-1:0] enable;    // Effective per-pin detect enables
    logic              refresh;   // Port access this cycle
    logic              mismatch;  // Any enabled pin differs from the latch

    modport ctrl (output level, output enable, output refresh, input mismatch);
    modport det  (input level, input enable, input refresh, output mismatch);
endinterface : pcd_det_if
`default_nettype wire

/* File: rtl/pcd_sync.sv */
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no word coherence is given.
`default_nettype none
module pcd_sync
    import pcd_pkg::*;
#(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // First stage feeds only the second
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : pcd_sync
`default_nettype wire

/* File: rtl/pcd_detect.sv */
// Comparison latch and mismatch detector for both ports.
// Assumes its reset is the power-on reset only, never master clear.
`default_nettype none
module pcd_detect
    import pcd_pkg::*;
(
    // Clock and power-on reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Detector side of the carrier
    pcd_det_if.det    dif
);
    logic [PINS_W-1:0] latch_r;
    logic [PINS_W-1:0] latch_nxt;

    // Any port access captures the live levels, ending the mismatch
    always_comb begin
        latch_nxt = latch_r;
        if (dif.refresh) begin
            latch_nxt = dif.level;  // [RL11]
        end
    end

    // Latch survives master clear; only power-on clears it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_r <= RST_CMP_LATCH;
        end else begin
            latch_r <= latch_nxt;  // [RL13]
        end
    end

    // OR of enabled per-pin differences
    assign dif.mismatch = |((dif.level ^ latch_r) & dif.enable);  // [RL9]
endmodule : pcd_detect
`default_nettype wire

/* File: rtl/pcd_top.sv */
// Pin configuration for the second port and change detection on both ports.
// Assumes a single-cycle register port and pins that are asynchronous to clk.
//
// What this block does
// [RL1] Pull-up on only with global enable, input direction, own bit, digital mode.
// [RL2] Pull-up bits at 7..4 and 1 reset to one; others read zero.
// [RL3] Analog-select bits at 6..4 and 1 reset to one; others read zero.
// [RL4] Analog pin loses digital input, pull-up and change detection.
// [RL5] Software sets the direction to input for every analog pin.
// [RL6] Every pin of both ports has its own change-detect enable; here first port pin four has none (MASK_CHANGE_A).
// [RL7] Power-on reset clears all change-detect enables.
// [RL8] Master-clear function on first port pin five forces its detection off.
// [RL9] Enabled pins compared with latch; differences ORed into the change flag.
// [RL10] Interrupt enable gates only the interrupt; flag keeps being set.
// [RL11] Port read or write refreshes the latch; mismatch keeps setting flag.
// [RL12] Service routine accesses a port, then clears the change flag.
// [RL13] Comparison latch keeps its value through master-clear reset.
// [RL14] A change during a port access may be missed.
// [RL15] With interrupt enable set, a change interrupt wakes from sleep.
// [RL16] Analog pins read as zero on digital reads of port data.
// [RL17] Pull-up off for outputs; all pull-ups off after power-on reset.
// [RL18] Pins synchronised first; flag set on the edge after a mismatch.
//
// The strobed register port and the register offsets were chosen for this implementation.
`default_nettype none
module pcd_top
    import pcd_pkg::*;
(
    // Clock and resets
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              master_clear_pin_rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Configuration: first port pin five used as master clear
    input  wire logic              master_clear_pin_function_sel,
    // First port pins
    input  wire logic [7:0]        port_a_in,
    output logic      [7:0]        port_a_out,
    output logic      [7:0]        port_a_oe,
    // Second port pins
    input  wire logic [7:0]        port_b_in,
    output logic      [7:0]        port_b_out,
    output logic      [7:0]        port_b_oe,
    output logic      [7:0]        port_b_pullup_on,
    // Events
    output logic                   irq,
    output logic                   wake_req
);
    // Either reset returns the control registers to their defaults
    logic ctl_rst_b;
    assign ctl_rst_b = rst_b & master_clear_pin_rst_b;

    // Synchronised pins and configuration
    logic [SYNC_W-1:0] sync_q;
    logic [7:0]        pin_a;
    logic [7:0]        pin_b;
    logic              master_clear_pin_sel;

    pcd_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in ({master_clear_pin_function_sel, port_b_in, port_a_in}),
        .sync_out (sync_q)
    );

    // Split the synchronised bus
    assign pin_a    = sync_q[7:0];  // [RL18]
    assign pin_b    = sync_q[15:8];
    assign master_clear_pin_sel = sync_q[16];

    // Software registers
    logic [7:0] out_a_r,   out_a_nxt;
    logic [7:0] out_b_r,   out_b_nxt;
    logic [7:0] dir_a_r,   dir_a_nxt;
    logic [7:0] dir_b_r,   dir_b_nxt;
    logic [7:0] wpu_b_r,   wpu_b_nxt;
    logic [7:0] ans_b_r,   ans_b_nxt;
    logic [7:0] cen_a_r,   cen_a_nxt;
    logic [7:0] cen_b_r,   cen_b_nxt;
    logic       flag_r,    flag_nxt;
    logic       ie_r,      ie_nxt;
    logic       glb_pu_r,  glb_pu_nxt;
    logic [7:0] rdata_r,   rdata_nxt;

    // Decoded strobes
    logic wr_a;
    logic wr_b;
    logic rd_a;
    logic rd_b;
    logic port_access;

    assign wr_a        = reg_wr && (reg_addr == OFS_PORT_A_DATA);
    assign wr_b        = reg_wr && (reg_addr == OFS_PORT_B_DATA);
    assign rd_a        = reg_rd && (reg_addr == OFS_PORT_A_DATA);
    assign rd_b        = reg_rd && (reg_addr == OFS_PORT_B_DATA);
    assign port_access = wr_a || wr_b || rd_a || rd_b;

    // Digital view of the pins; analog pins read zero
    logic [7:0] dig_a;
    logic [7:0] dig_b;

    assign dig_a = pin_a & MASK_PORT_A;
    assign dig_b = pin_b & MASK_PORT_B & ~ans_b_r;  // [RL16] [RL4]

    // Change detector
    pcd_det_if dif ();

    // Effective enables: master-clear pin and analog pins excluded
    always_comb begin
        dif.enable        = {cen_b_r & MASK_CHANGE_B & ~ans_b_r, cen_a_r & MASK_CHANGE_A};  // [RL6] [RL4]
        if (master_clear_pin_sel) begin
            dif.enable[BIT_MASTER_CLEAR_PIN_PIN] = 1'b0;  // [RL8]
        end
    end

    assign dif.level   = {dig_b, dig_a};
    assign dif.refresh = port_access;  // [RL11] [RL14]

    pcd_detect u_detect (
        .clk   (clk),
        .rst_b (rst_b),
        .dif   (dif)
    );

    // Next values of the configuration registers
    always_comb begin
        out_a_nxt  = out_a_r;
        out_b_nxt  = out_b_r;
        dir_a_nxt  = dir_a_r;
        dir_b_nxt  = dir_b_r;
        wpu_b_nxt  = wpu_b_r;
        ans_b_nxt  = ans_b_r;
        cen_a_nxt  = cen_a_r;
        cen_b_nxt  = cen_b_r;
        ie_nxt     = ie_r;
        glb_pu_nxt = glb_pu_r;
        if (reg_wr) begin
            case (reg_addr)
                OFS_PORT_A_DATA:      out_a_nxt  = reg_wdata & MASK_PORT_A;
                OFS_PORT_B_DATA:      out_b_nxt  = reg_wdata & MASK_PORT_B;
                OFS_PORT_A_DIRECTION: dir_a_nxt  = reg_wdata & MASK_PORT_A;
                OFS_PORT_B_DIRECTION: dir_b_nxt  = reg_wdata & MASK_PORT_B;
                OFS_PORT_B_PULLUP:    wpu_b_nxt  = reg_wdata & MASK_PULLUP_B;  // [RL2]
                OFS_PORT_B_ANALOG:    ans_b_nxt  = reg_wdata & MASK_ANALOG_B;  // [RL3]
                OFS_CHANGE_EN_A:      cen_a_nxt  = reg_wdata & MASK_CHANGE_A;  // [RL6]
                OFS_CHANGE_EN_B:      cen_b_nxt  = reg_wdata & MASK_CHANGE_B;
                OFS_INT_MASK:         ie_nxt     = reg_wdata[BIT_CHANGE_IE];
                OFS_PULLUP_CTRL:      glb_pu_nxt = reg_wdata[BIT_PULLUP_GLB];
                default:              ;
            endcase
        end
    end

    // Change flag: write one clears, a mismatch sets and wins over the clear
    always_comb begin
        flag_nxt = flag_r;
        if (reg_wr && (reg_addr == OFS_INT_STATUS) && reg_wdata[BIT_CHANGE_FLAG]) begin
            flag_nxt = 1'b0;
        end
        if (dif.mismatch) begin
            flag_nxt = 1'b1;  // [RL9] [RL11] [RL18]
        end
    end

    // Read data for the cycle after the read strobe
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_PORT_A_DATA:      rdata_nxt = dig_a;
                OFS_PORT_B_DATA:      rdata_nxt = dig_b;  // [RL16]
                OFS_PORT_A_DIRECTION: rdata_nxt = dir_a_r;
                OFS_PORT_B_DIRECTION: rdata_nxt = dir_b_r;
                OFS_PORT_B_PULLUP:    rdata_nxt = wpu_b_r;  // [RL2]
                OFS_PORT_B_ANALOG:    rdata_nxt = ans_b_r;  // [RL3]
                OFS_CHANGE_EN_A:      rdata_nxt = cen_a_r;
                OFS_CHANGE_EN_B:      rdata_nxt = cen_b_r;
                OFS_INT_STATUS:       rdata_nxt[BIT_CHANGE_FLAG] = flag_r;
                OFS_INT_MASK:         rdata_nxt[BIT_CHANGE_IE]   = ie_r;
                OFS_PULLUP_CTRL:      rdata_nxt[BIT_PULLUP_GLB]  = glb_pu_r;
                default:              rdata_nxt = '0;
            endcase
        end
    end

    // Control registers; either reset restores them
    always_ff @(posedge clk or negedge ctl_rst_b) begin
        if (!ctl_rst_b) begin
            out_a_r  <= RST_OUT_DATA;
            out_b_r  <= RST_OUT_DATA;
            dir_a_r  <= RST_DIRECTION;
            dir_b_r  <= RST_DIRECTION & MASK_PORT_B;  // Missing pins read zero
            wpu_b_r  <= RST_PULLUP_B;   // [RL2]
            ans_b_r  <= RST_ANALOG_B;   // [RL3]
            cen_a_r  <= RST_CHANGE;     // [RL7]
            cen_b_r  <= RST_CHANGE;     // [RL7]
            flag_r   <= RST_FLAG;
            ie_r     <= RST_INT_EN;
            glb_pu_r <= RST_PULLUP_GLB; // [RL17]
            rdata_r  <= '0;
        end else begin
            out_a_r  <= out_a_nxt;
            out_b_r  <= out_b_nxt;
            dir_a_r  <= dir_a_nxt;
            dir_b_r  <= dir_b_nxt;
            wpu_b_r  <= wpu_b_nxt;
            ans_b_r  <= ans_b_nxt;
            cen_a_r  <= cen_a_nxt;
            cen_b_r  <= cen_b_nxt;
            flag_r   <= flag_nxt;
            ie_r     <= ie_nxt;
            glb_pu_r <= glb_pu_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Pull-up only for a digital input with both enables set
    assign port_b_pullup_on = {8{glb_pu_r}} & dir_b_r & wpu_b_r & ~ans_b_r;  // [RL1] [RL4] [RL17]

    // Output drivers; analog mode does not affect them
    always_comb begin
        port_a_out = out_a_r;
        port_a_oe  = ~dir_a_r & MASK_PORT_A;
        port_b_out = out_b_r;
        port_b_oe  = ~dir_b_r & MASK_PORT_B;
        // Open-drain pin only ever pulls low
        port_b_out[BIT_OPEN_DRAIN] = 1'b0;
        port_b_oe[BIT_OPEN_DRAIN]  = ~dir_b_r[BIT_OPEN_DRAIN] & ~out_b_r[BIT_OPEN_DRAIN];
    end

    // Interrupt and wake share the enable; the flag does not depend on it
    assign irq      = flag_r & ie_r;  // [RL10]
    assign wake_req = flag_r & ie_r;  // [RL15]
endmodule : pcd_top
`default_nettype wire

/* File: dv/pcd_pin_model.sv */
// Model of the external signals on both ports' pins.
// Assumes the bench picks which pins an outside source drives.
`default_nettype none
module pcd_pin_model (
    // Clock for the floating pattern
    input  wire logic       clk,
    // Pin drivers and pull-ups of the block
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe,
    input  wire logic [7:0] b_pu,
    // Outside sources
    input  wire logic [7:0] a_drv,
    input  wire logic [7:0] a_ext,
    input  wire logic [7:0] b_drv,
    input  wire logic [7:0] b_ext,
    // Resulting pin levels
    output logic      [7:0] a_pin,
    output logic      [7:0] b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_r = 8'h55;
    // An undriven pin with no pull-up wanders instead of holding
    always @(posedge clk) float_r <= ~float_r;
    // The block's own driver wins, then an outside source, then pull-up
    assign a_pin = (a_oe & a_out) | (~a_oe & a_drv & a_ext) | (~a_oe & ~a_drv & float_r);
    assign b_pin = (b_oe & b_out) | (~b_oe & b_drv & b_ext) | (~b_oe & ~b_drv & (b_pu | float_r));
endmodule // pcd_pin_model
`default_nettype wire

/* File: dv/pcd_chk.sv */
// Port-level checker for the pin configuration and change-detect block.
// Assumes pcd_pkg is compiled first; bound into pcd_top below.
`default_nettype none
module pcd_chk
    import pcd_pkg::*;
(
    // Clock and resets
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              master_clear_pin_rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    // Pins and events
    input  wire logic [7:0]        port_b_oe,
    input  wire logic [7:0]        port_b_pullup_on,
    input  wire logic              irq,
    input  wire logic              wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !master_clear_pin_rst_b);
    // Pull-ups and drivers never fight
    a_pullup_output: assert property ((port_b_pullup_on & port_b_oe) == 8'h00)
        else $error("pull-up on for a driven pin");
    a_wake_irq: assert property (wake_req == irq)
        else $error("wake request differs from interrupt");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_pullup_bits: assert property (reg_rd && reg_addr == OFS_PORT_B_PULLUP |=> (reg_rdata & 8'h0d) == 8'h00)
        else $error("pull-up gap bits read nonzero");
    a_analog_bits: assert property (reg_rd && reg_addr == OFS_PORT_B_ANALOG |=> (reg_rdata & 8'h8d) == 8'h00)
        else $error("analog gap bits read nonzero");
    a_analog_pullup: assert property (reg_wr && reg_addr == OFS_PORT_B_ANALOG && reg_wdata == 8'h72
        |=> (port_b_pullup_on & 8'h72) == 8'h00)
        else $error("pull-up on for analog pin");
    a_dir_pullup: assert property (reg_wr && reg_addr == OFS_PORT_B_DIRECTION
        |=> (port_b_pullup_on & ~$past(reg_wdata)) == 8'h00)
        else $error("pull-up on for output pin");
    a_global_off: assert property (reg_wr && reg_addr == OFS_PULLUP_CTRL && !reg_wdata[0]
        |=> port_b_pullup_on == 8'h00)
        else $error("pull-up on with global control off");
    a_ie_gate: assert property (reg_wr && reg_addr == OFS_INT_MASK && !reg_wdata[0] |=> !irq)
        else $error("interrupt with enable clear");
    a_por_quiet: assert property ($rose(rst_b) |-> !irq && port_b_pullup_on == 8'h00)
        else $error("pull-up or interrupt after power-on");
endmodule // pcd_chk
bind pcd_top pcd_chk u_chk (.clk, .rst_b, .master_clear_pin_rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_b_oe, .port_b_pullup_on, .irq, .wake_req);
`default_nettype wire

/* File: dv/pcd_top_tb.sv */
// Self-checking bench for pcd_top: register calls and pin changes.
// Assumes pcd_pkg, the design, checker and pin model are compiled first.
`default_nettype none
module pcd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcd_pkg::*;
    logic       clk = 0, rst_b = 0, master_clear_pin_rst_b = 1, sel = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, a_ext = 0, b_ext = 0, a_drv = 8'hff, b_drv = 8'hff;
    logic       reg_wr = 0, reg_rd = 0;
    wire  [7:0] reg_rdata, a_out, a_oe, b_out, b_oe, b_pu, a_pin, b_pin;
    wire        irq, wake_req;
    int         n_errors = 0, compares = 0, cycles = 0;
    logic [7:0] rv [10] = '{8'hff, 8'hf3, 8'hf2, 8'h72, 0, 0, 0, 0, 0, 0};
    logic [7:0] mk [4] = '{8'hf2, 8'h72, 8'hef, 8'hf3};

    always #20 clk = ~clk;
    pcd_top u_dut (.clk(clk), .rst_b(rst_b), .master_clear_pin_rst_b(master_clear_pin_rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_clear_pin_function_sel(sel), .port_a_in(a_pin), .port_a_out(a_out), .port_a_oe(a_oe),
        .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pullup_on(b_pu),
        .irq(irq), .wake_req(wake_req));
    pcd_pin_model u_pins (.clk(clk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .b_pu(b_pu), .a_drv(a_drv), .a_ext(a_ext), .b_drv(b_drv), .b_ext(b_ext),
        .a_pin(a_pin), .b_pin(b_pin));

    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    // New pin levels, then time for synchronisers and flag
    task automatic pins(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        a_ext <= a;
        b_ext <= b;
        repeat (5) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) rd(4'(i + 2), rv[i]);
        chk("pullup", 8'h00, b_pu);
        for (int i = 4; i < 8; i++) wr(4'(i), 8'hff);
        for (int i = 0; i < 4; i++) rd(4'(i + 4), mk[i]);
        // Pull-up gating
        wr(OFS_PORT_B_ANALOG, 8'h00);
        wr(OFS_PULLUP_CTRL, 8'h01);
        #1 chk("pullup", 8'hf2, b_pu);
        wr(OFS_PORT_B_DIRECTION, 8'h7f);
        #1 chk("pullup", 8'h72, b_pu);
        wr(OFS_PORT_B_ANALOG, 8'h02);
        #1 chk("pullup", 8'h70, b_pu);
        wr(OFS_PORT_B_DIRECTION, 8'hff);
        // Analog pins read zero
        pins(8'h00, 8'hff);
        rd(OFS_PORT_B_DATA, 8'hf1);
        wr(OFS_PORT_B_ANALOG, 8'h72);
        rd(OFS_PORT_B_DATA, 8'h81);
        // Change on the first port with interrupt enabled
        wr(OFS_INT_MASK, 8'h01);
        rd(OFS_PORT_A_DATA, 8'h00);
        wr(OFS_INT_STATUS, 8'h01);
        rd(OFS_INT_STATUS, 8'h00);
        pins(8'h01, 8'hff);
        chk("irq", 8'h01, {7'h0, irq});
        wr(OFS_INT_STATUS, 8'h01);
        rd(OFS_INT_STATUS, 8'h01);
        rd(OFS_PORT_A_DATA, 8'h01);
        wr(OFS_INT_STATUS, 8'h01);
        rd(OFS_INT_STATUS, 8'h00);
        // Interrupt enable clear: flag still set
        wr(OFS_INT_MASK, 8'h00);
        pins(8'h03, 8'hff);
        chk("irq", 8'h00, {7'h0, irq});
        rd(OFS_INT_STATUS, 8'h01);
        rd(OFS_PORT_A_DATA, 8'h03);
        wr(OFS_INT_STATUS, 8'h01);
        // Pin five as master clear is ignored, then counts again
        @(posedge clk) sel <= 1'b1;
        pins(8'h23, 8'hff);
        rd(OFS_INT_STATUS, 8'h00);
        @(posedge clk) sel <= 1'b0;
        pins(8'h23, 8'hff);
        rd(OFS_INT_STATUS, 8'h01);
        rd(OFS_PORT_A_DATA, 8'h23);
        rd(OFS_PORT_B_DATA, 8'h81);
        wr(OFS_INT_STATUS, 8'h01);
        // Analog and missing pins of the second port do not count
        pins(8'h23, 8'h83);
        rd(OFS_INT_STATUS, 8'h00);
        wr(OFS_PORT_B_ANALOG, 8'h70);
        pins(8'h23, 8'h81);
        rd(OFS_INT_STATUS, 8'h01);
        // Latch survives master clear
        pins(8'h22, 8'h81);
        @(posedge clk) master_clear_pin_rst_b <= 1'b0;
        @(posedge clk) master_clear_pin_rst_b <= 1'b1;
        rd(OFS_INT_STATUS, 8'h00);
        rd(OFS_CHANGE_EN_A, 8'h00);
        wr(OFS_CHANGE_EN_A, 8'h01);
        rd(OFS_INT_STATUS, 8'h01);
        tally_and_finish();
    end
endmodule // pcd_top_tb
`default_nettype wire
